//--- src/ciop_pkg.sv
// package for the camera image output port: formats, frame geometry, field positions
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package ciop_pkg;
    localparam int PIX_W = 10;
    localparam int PAR_W = 8;
    localparam int LSB_W = 2;
    localparam int HI_LSB = 2;
    localparam int HI_MSB = 9;
    localparam logic [1:0] FMT_RGB8 = 2'h0;
    localparam logic [1:0] FMT_BAYER10 = 2'h1;
    localparam logic [1:0] FMT_BT656 = 2'h2;
    localparam logic [9:0] BLANK_VALUE = 10'h000;
    localparam logic [6:0] ADDR_HIGH_SEL = 7'h5D;
    localparam logic [6:0] ADDR_LOW_SEL = 7'h48;
    localparam int DEF_ACT_COLS = 16;
    localparam int DEF_ACT_ROWS = 8;
    localparam int DEF_HBLANK = 4;
    localparam int DEF_VBLANK = 2;
    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_ACTIVE,
        ST_HBLANK,
        ST_VBLANK
    } ciop_state_t;
endpackage
`default_nettype wire

//--- src/ciop_top.sv
// camera image output port: raw or processed pixels sent over an 8/10-bit parallel port or a
// serial lane, with frame and line qualifiers, standby after reset and boot-mode select.
// assumes pixel source is on the link clock, always offering a pixel; pins synchronised here.
`default_nettype none
module ciop_top #(
    parameter int ACT_COLS = ciop_pkg::DEF_ACT_COLS,
    parameter int ACT_ROWS = ciop_pkg::DEF_ACT_ROWS,
    parameter int HBLANK = ciop_pkg::DEF_HBLANK,
    parameter int VBLANK = ciop_pkg::DEF_VBLANK
) (
    // system clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // link clock (pixel domain)
    input wire logic reference_clock_in,
    // pins, asynchronous to both clocks
    input wire logic reset_n_pin_in,
    input wire logic boot_stream_pin_in,
    input wire logic output_enable_n_in,
    input wire logic serial_address_select_in,
    input wire logic test_reset_n_in,
    // configuration, system domain
    input wire logic use_raw_in,
    input wire logic serial_mode_in,
    input wire logic [1:0] format_in,
    input wire logic host_start_in,
    input wire logic host_standby_in,
    // pixel sources, link domain
    input wire logic [ciop_pkg::PIX_W-1:0] raw_pixel_in,
    input wire logic [ciop_pkg::PIX_W-1:0] proc_pixel_in,
    // parallel port
    output logic [ciop_pkg::PAR_W-1:0] data_out,
    output logic [ciop_pkg::LSB_W-1:0] data_lsb_out,
    output logic frame_qualifier_short_out,
    output logic line_qualifier_short_out,
    output logic pixel_clock_out,
    output logic parallel_oe_out,
    // serial lane, sampled word form
    output logic [ciop_pkg::PIX_W-1:0] serial_word_out,
    output logic serial_valid_out,
    // status
    output logic streaming_out,
    output logic [6:0] serial_bus_address_out
);
    initial begin
        if (ACT_COLS < 1 || ACT_ROWS < 1 || HBLANK < 1 || VBLANK < 1) begin
            $error("ciop_top: frame geometry must be at least one");
        end
    end

    localparam int CW = $clog2(ACT_COLS + HBLANK + 1);
    localparam int RW = $clog2(ACT_ROWS + VBLANK + 1);

    // system domain state
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] boot_sync;
        logic [1:0] addr_sync;
        logic booted;
        logic stream;
        logic raw_sel;
        logic serial_sel;
        logic [1:0] fmt;
        logic [6:0] addr;
    } ciop_sys_t;

    ciop_sys_t s_q, s_d;

    // link domain state
    typedef struct packed {
        logic [1:0] stream_sync;
        logic [1:0] oe_n_sync;
        logic [1:0] rst_sync;
        ciop_pkg::ciop_state_t st;
        logic [CW-1:0] col;
        logic [RW-1:0] row;
        logic [ciop_pkg::PAR_W-1:0] dat;
        logic [ciop_pkg::LSB_W-1:0] lsb;
        logic fq;
        logic lq;
        logic [ciop_pkg::PIX_W-1:0] sword;
        logic svalid;
    } ciop_link_t;

    ciop_link_t l_q, l_d;

    wire logic dev_reset = reset_in || !s_q.rst_sync[1];

    always_comb begin
        s_d = s_q;
        // a floating pin reads high at the pad, so an unwired reset or boot pin arrives here as one
        s_d.rst_sync = {s_q.rst_sync[0], reset_n_pin_in};
        s_d.boot_sync = {s_q.boot_sync[0], boot_stream_pin_in};
        s_d.addr_sync = {s_q.addr_sync[0], serial_address_select_in};
        s_d.addr = s_q.addr_sync[1] ? ciop_pkg::ADDR_HIGH_SEL : ciop_pkg::ADDR_LOW_SEL;
        if (dev_reset) begin
            s_d.booted = 1'b0;
            s_d.stream = 1'b0;
        end else if (!s_q.booted) begin
            // boot mode is caught on the first clock after release, never by the reset itself
            s_d.booted = 1'b1;
            s_d.stream = s_q.boot_sync[1];
        end else if (host_start_in) begin
            s_d.stream = 1'b1;
        end else if (host_standby_in) begin
            s_d.stream = 1'b0;
        end
        // config only changes in standby so the link domain sees stable values while streaming
        if (!s_q.stream) begin
            s_d.raw_sel = use_raw_in;
            s_d.serial_sel = serial_mode_in;
            s_d.fmt = format_in;
        end
        if (reset_in) begin
            s_d.rst_sync = 2'h0;
            s_d.boot_sync = 2'h0;
            s_d.addr_sync = 2'h0;
            s_d.raw_sel = 1'b0;
            s_d.serial_sel = 1'b0;
            s_d.fmt = ciop_pkg::FMT_RGB8;
            s_d.addr = ciop_pkg::ADDR_LOW_SEL;
        end
    end

    always_ff @(posedge clk_in) begin
        s_q <= s_d;
    end

    // pixel chosen by the quasi-static raw select
    logic [ciop_pkg::PIX_W-1:0] pix;
    assign pix = s_q.raw_sel ? raw_pixel_in : proc_pixel_in;

    wire logic link_stream = l_q.stream_sync[1] && l_q.rst_sync[1];
    wire logic last_col = l_q.col == CW'(ACT_COLS + HBLANK - 1);
    wire logic last_row = l_q.row == RW'(ACT_ROWS + VBLANK - 1);

    always_comb begin
        l_d = l_q;
        l_d.stream_sync = {l_q.stream_sync[0], s_q.stream};
        l_d.oe_n_sync = {l_q.oe_n_sync[0], output_enable_n_in};
        l_d.rst_sync = {l_q.rst_sync[0], !dev_reset};
        l_d.dat = ciop_pkg::BLANK_VALUE[ciop_pkg::PAR_W-1:0];
        l_d.lsb = ciop_pkg::BLANK_VALUE[ciop_pkg::LSB_W-1:0];
        l_d.fq = 1'b0;
        l_d.lq = 1'b0;
        l_d.sword = ciop_pkg::BLANK_VALUE;
        l_d.svalid = 1'b0;
        if (!link_stream) begin
            l_d.st = ciop_pkg::ST_STANDBY;
            l_d.col = '0;
            l_d.row = '0;
        end else begin
            l_d.col = last_col ? '0 : l_q.col + CW'(1);
            if (last_col) begin
                l_d.row = last_row ? '0 : l_q.row + RW'(1);
            end
            // progressive scan: active pixels, then line blank, then frame blank
            if (l_d.row >= RW'(ACT_ROWS)) begin
                l_d.st = ciop_pkg::ST_VBLANK;
            end else if (l_d.col >= CW'(ACT_COLS)) begin
                l_d.st = ciop_pkg::ST_HBLANK;
            end else begin
                l_d.st = ciop_pkg::ST_ACTIVE;
            end
            if (l_d.st == ciop_pkg::ST_ACTIVE) begin
                if (s_q.serial_sel) begin
                    l_d.sword = pix;
                    l_d.svalid = 1'b1;
                end else begin
                    if (s_q.fmt == ciop_pkg::FMT_BAYER10) begin
                        l_d.dat = pix[ciop_pkg::HI_MSB:ciop_pkg::HI_LSB];
                        l_d.lsb = pix[ciop_pkg::LSB_W-1:0];
                    end else begin
                        l_d.dat = pix[ciop_pkg::PAR_W-1:0];
                    end
                    // embedded-sync keeps qualifiers low; no timing codes are added to the data
                    l_d.lq = s_q.fmt != ciop_pkg::FMT_BT656;
                end
            end
            if (!s_q.serial_sel && l_d.st != ciop_pkg::ST_VBLANK) begin
                l_d.fq = s_q.fmt != ciop_pkg::FMT_BT656;
            end
        end
        if (!l_q.rst_sync[1]) begin
            l_d.st = ciop_pkg::ST_STANDBY;
            l_d.col = '0;
            l_d.row = '0;
        end
    end

    // link registers have no reset of their own: the synchronised device reset returns state, column and row to standby and zero
    always_ff @(posedge reference_clock_in) begin
        l_q <= l_d;
    end

    // parallel drive only when streaming on the parallel port with enable low
    assign parallel_oe_out = link_stream && !s_q.serial_sel && !l_q.oe_n_sync[1];
    assign data_out = l_q.dat;
    assign data_lsb_out = l_q.lsb;
    assign frame_qualifier_short_out = l_q.fq;
    assign line_qualifier_short_out = l_q.lq;
    // gated copy of the link clock; data changes on the rising edge, host samples on the falling
    assign pixel_clock_out = reference_clock_in && parallel_oe_out;
    assign serial_word_out = (link_stream && s_q.serial_sel) ? l_q.sword : ciop_pkg::BLANK_VALUE;
    assign serial_valid_out = link_stream && s_q.serial_sel && l_q.svalid;
    assign streaming_out = s_q.stream;
    assign serial_bus_address_out = s_q.addr;

    wire logic unused_test = test_reset_n_in;
endmodule
`default_nettype wire

//--- tb/ciop_sva.sv
// checker: port, qualifier and standby relations of ciop_top
// assumes reset_in lasts four clk_in cycles
`default_nettype none
module ciop_sva (
    // clock, reset and inputs
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic output_enable_n_in,
    input wire logic [1:0] format_in,
    // outputs
    input wire logic [7:0] data_out,
    input wire logic [1:0] data_lsb_out,
    input wire logic frame_qualifier_short_out,
    input wire logic line_qualifier_short_out,
    input wire logic pixel_clock_out,
    input wire logic parallel_oe_out,
    input wire logic serial_valid_out,
    input wire logic streaming_out
);
    // link outputs never move on a clk_in edge, so sampling them here is race free
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    rst_quiet_a: assert property ($fell(reset_in) |-> !streaming_out && !parallel_oe_out) else $error("live");
    stop_quiet_a: assert property (!streaming_out [*8]
        |-> !parallel_oe_out && !serial_valid_out) else $error("output while idle");
    one_port_a: assert property (!(parallel_oe_out && serial_valid_out)) else $error("both ports");
    oe_float_a: assert property (output_enable_n_in [*4] |-> !parallel_oe_out) else $error("driven");
    clk_gate_a: assert property (!parallel_oe_out |-> !pixel_clock_out) else $error("pixel clock");
    lv_in_fv_a: assert property (line_qualifier_short_out |-> frame_qualifier_short_out) else $error("frame");
    blank_zero_a: assert property ((parallel_oe_out && !line_qualifier_short_out && format_in != 2'h2) [*2]
        |-> data_out == 8'h00 && data_lsb_out == 2'h0) else $error("blank data");
    bt656_a: assert property ((parallel_oe_out && format_in == ciop_pkg::FMT_BT656) [*2]
        |-> !frame_qualifier_short_out && !line_qualifier_short_out) else $error("qualifiers");
endmodule
bind ciop_top ciop_sva chk (.*);
`default_nettype wire

//--- tb/ciop_host_rx.sv
// host capture model: last word taken from the parallel port
// assumes the word is the data pins above the two low-bit pins
`default_nettype none
module ciop_host_rx (
    // parallel port
    input wire logic pclk_in,
    input wire logic frame_in,
    input wire logic line_in,
    input wire logic [9:0] pix_in,
    // capture result
    output logic [9:0] word_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // falling edge stays clear of the edge that launches the data
    always @(negedge pclk_in) if (frame_in && line_in) word_out <= pix_in;
endmodule
`default_nettype wire

//--- tb/test_camera_image_output_port.sv
// bench for ciop_top: boot stream, host start and standby, formats, serial lane, resets
// assumes ciop_host_rx and the bound checker are compiled
`default_nettype none
module test_camera_image_output_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, reference_clock_in = 1'b0, reset_in, reset_n_pin_in, boot_stream_pin_in;
    logic output_enable_n_in, serial_address_select_in, test_reset_n_in, use_raw_in, serial_mode_in;
    logic host_start_in, host_standby_in, frame_qualifier_short_out, line_qualifier_short_out;
    logic pixel_clock_out, parallel_oe_out, serial_valid_out, streaming_out;
    logic [1:0] format_in, data_lsb_out;
    logic [7:0] data_out;
    logic [6:0] serial_bus_address_out;
    logic [9:0] raw_pixel_in, proc_pixel_in, serial_word_out, word;
    int num_errors = 0;
    int n_checks = 0;
    ciop_top dut (.*);
    ciop_host_rx rx (.pclk_in(pixel_clock_out), .frame_in(frame_qualifier_short_out),
        .line_in(line_qualifier_short_out), .pix_in({data_out, data_lsb_out}), .word_out(word));
    initial forever #12.5 clk_in = ~clk_in;
    initial #3.3 forever #7.5 reference_clock_in = ~reference_clock_in;
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic check(input logic [9:0] got, exp);
        n_checks++;
        num_errors += int'(got !== exp);
        if (got !== exp) $display("unexpected at %0t got %h exp %h", $time, got, exp);
    endtask
    task automatic host(input logic on);
        {host_start_in, host_standby_in} = {on, !on};
        tick(1);
        {host_start_in, host_standby_in} = 2'b00;
        for (int i = 0; i < 20 && streaming_out !== on; i++) tick(1);
        tick(10);
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100us num_errors++;
        tally_and_finish;
    end
    initial begin
        {reset_in, boot_stream_pin_in, reset_n_pin_in, serial_address_select_in, use_raw_in} = 5'h1F;
        {output_enable_n_in, serial_mode_in, host_start_in, host_standby_in, test_reset_n_in} = 5'h00;
        {format_in, raw_pixel_in, proc_pixel_in} = {ciop_pkg::FMT_RGB8, 10'h2A5, 10'h1C3};
        tick(4);
        reset_in = 1'b0;
        tick(6);
        check(10'(streaming_out), 10'h001);
        tick(200);
        check(word, 10'h294);
        check(10'(serial_bus_address_out), 10'(ciop_pkg::ADDR_HIGH_SEL));
        {serial_address_select_in, use_raw_in, format_in} = {2'b00, ciop_pkg::FMT_BAYER10};
        host(1'b0);
        check(10'(serial_bus_address_out), 10'(ciop_pkg::ADDR_LOW_SEL));
        host(1'b1);
        tick(200);
        check(word, 10'h1C3);
        host(1'b0);
        format_in = ciop_pkg::FMT_BT656;
        host(1'b1);
        tick(100);
        host(1'b0);
        {output_enable_n_in, serial_mode_in} = 2'b11;
        host(1'b1);
        check(10'(streaming_out), 10'h001);
        for (int i = 0; i < 50 && serial_valid_out !== 1'b1; i++) tick(1);
        check(serial_word_out, 10'h1C3);
        {reset_in, boot_stream_pin_in} = 2'b10;
        tick(4);
        reset_in = 1'b0;
        tick(10);
        check(10'(streaming_out), 10'h000);
        host(1'b1);
        reset_n_pin_in = 1'b0;
        tick(5);
        check(10'(streaming_out), 10'h000);
        tally_and_finish;
    end
endmodule
`default_nettype wire
